// ---- pkg/csss_pkg.sv ----
package csss_pkg;
  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int SPEED_W = 14;
  localparam int REF_W = 16;
  localparam int TIME_W = 14;
  localparam int MODE_W = 4;
  localparam int DEN_W = 32;
  localparam int CNT_W = 20;
  localparam int SYNC_W = 4;

  // ----------------------------------------------------------------
  // setting ranges and reset values
  // ----------------------------------------------------------------
  localparam logic [TIME_W-1:0] TIME_MAX = 14'h2710;
  localparam logic [TIME_W-1:0] TIME_RESET = 14'h0000;
  localparam logic signed [REF_W-1:0] REF_ZERO = 16'sh0000;

  // ----------------------------------------------------------------
  // control method codes
  // ----------------------------------------------------------------
  localparam logic [MODE_W-1:0] MODE_STOP = 4'h3;
  localparam logic [MODE_W-1:0] MODE_ASPEED = 4'h4;
  localparam logic [MODE_W-1:0] MODE_PULSE = 4'h5;
  localparam logic [MODE_W-1:0] MODE_ATORQUE = 4'h6;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int NS_PER_MS = 1000000;
  localparam int CYCLES_PER_MS = NS_PER_MS / CLK_PERIOD_NS;
  localparam int SAMPLE_MS = 1;
  localparam int SAMPLE_CYCLES = SAMPLE_MS * CYCLES_PER_MS;
  localparam int LATENCY_MAX_MS = 2;

  // ----------------------------------------------------------------
  // sync bit positions
  // ----------------------------------------------------------------
  localparam int SYNC_A = 0;
  localparam int SYNC_B = 1;
  localparam int SYNC_D = 2;
  localparam int SYNC_P = 3;

  // ----------------------------------------------------------------
  // reference source
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_SPEED,
    SRC_ANALOG_SPEED,
    SRC_PULSE,
    SRC_TORQUE
  } csss_src_t;
endpackage

// ---- verilog/csss_sync.sv ----
`timescale 1ns/10ps
module csss_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] stage1;

  // ----------------------------------------------------------------
  // two-flop synchroniser, first stage feeds only the second
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      stage1 <= '1;
      sync_o <= '1;
    end
    else
    begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule

// ---- verilog/csss_speed_select.sv ----
`timescale 1ns/10ps
// Contract
// - accel time held, 0..10000 ms accepted, resets 0, speed control only
// - decel time held, 0..10000 ms accepted, resets 0, speed control only
// - ramp from standstill to maximum speed takes exactly the accel time
// - ramp from maximum speed to standstill takes exactly the decel time
// - both times zero means reference changes apply immediately
// - mode 3, both selects off, internal reference is zero
// - both selects off: analog speed mode 4, pulse mode 5, torque mode 6
// - modes 3-6: A off B on speed one, both on two, A on B off three
// - direction input 0 forward, 1 reverse while contact selection active
// - contact inputs are active low: high is off, low is on
// - without contact selection, selects are fwd/rev torque limit enables
// - without contact selection, direction input is proportional control etc
// - contact selection needs all three functions assigned to inputs
// - mode 5 ramps apply only to preset speeds, never to pulses
// - preset-to-pulse switch while running blocks pulses until positioning done
// - speed-select changes are sampled within 2 ms
// - presets above motor maximum speed are clamped to maximum
module csss_speed_select
  import csss_pkg::*;
#(
  parameter int CYCLES_MS = csss_pkg::CYCLES_PER_MS,
  parameter int SAMPLE_CNT = csss_pkg::SAMPLE_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // contact pins, active low
  input wire logic speed_select_a_n_i,
  input wire logic speed_select_b_n_i,
  input wire logic direction_select_n_i,
  input wire logic ref_pulse_i,
  // configuration
  input wire logic [csss_pkg::MODE_W-1:0] control_method_select_i,
  input wire logic assign_a_i,
  input wire logic assign_b_i,
  input wire logic assign_d_i,
  input wire logic time_wr_i,
  input wire logic [csss_pkg::TIME_W-1:0] accel_ramp_time_i,
  input wire logic [csss_pkg::TIME_W-1:0] decel_ramp_time_i,
  input wire logic [csss_pkg::SPEED_W-1:0] preset_speed_one_i,
  input wire logic [csss_pkg::SPEED_W-1:0] preset_speed_two_i,
  input wire logic [csss_pkg::SPEED_W-1:0] preset_speed_three_i,
  input wire logic [csss_pkg::SPEED_W-1:0] max_speed_i,
  // references from other loops
  input wire logic signed [csss_pkg::REF_W-1:0] analog_speed_ref_i,
  input wire logic signed [csss_pkg::REF_W-1:0] analog_torque_ref_i,
  input wire logic position_done_i,
  // reference outputs
  output logic signed [csss_pkg::REF_W-1:0] speed_ref_o,
  output logic signed [csss_pkg::REF_W-1:0] torque_ref_o,
  output csss_pkg::csss_src_t ref_source_o,
  output logic ref_pulse_o,
  output logic pulse_blocked_o,
  output logic position_done_n_o,
  // status and alternate functions
  output logic contact_mode_o,
  output logic direction_reverse_o,
  output logic fwd_torque_limit_o,
  output logic rev_torque_limit_o,
  output logic prop_control_o,
  output logic [csss_pkg::TIME_W-1:0] accel_ramp_time_o,
  output logic [csss_pkg::TIME_W-1:0] decel_ramp_time_o
);
  import csss_pkg::*;

  // ----------------------------------------------------------------
  // input synchronisation
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] pin_sync;
  assign pin_raw = {ref_pulse_i, direction_select_n_i, speed_select_b_n_i, speed_select_a_n_i};

  csss_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .async_i(pin_raw),
    .sync_o(pin_sync)
  );

  wire sel_a_on = ~pin_sync[SYNC_A];
  wire sel_b_on = ~pin_sync[SYNC_B];
  wire dir_on = ~pin_sync[SYNC_D];
  wire pulse_in = ~pin_sync[SYNC_P];

  // ----------------------------------------------------------------
  // ramp time settings
  // ----------------------------------------------------------------
  logic [TIME_W-1:0] accel_time;
  logic [TIME_W-1:0] decel_time;
  wire accel_ok = accel_ramp_time_i <= TIME_MAX;
  wire decel_ok = decel_ramp_time_i <= TIME_MAX;

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      accel_time <= TIME_RESET;
      decel_time <= TIME_RESET;
    end
    else if (time_wr_i)
    begin
      accel_time <= accel_ok ? accel_ramp_time_i : accel_time;
      decel_time <= decel_ok ? decel_ramp_time_i : decel_time;
    end
  end

  assign accel_ramp_time_o = accel_time;
  assign decel_ramp_time_o = decel_time;

  // ----------------------------------------------------------------
  // mode decode and contact sampling
  // ----------------------------------------------------------------
  wire mode_contact = (control_method_select_i >= MODE_STOP)
    && (control_method_select_i <= MODE_ATORQUE);
  wire contact_mode = mode_contact && assign_a_i && assign_b_i && assign_d_i;

  logic [CNT_W-1:0] sample_cnt;
  logic samp_a;
  logic samp_b;
  logic samp_d;
  wire sample_tick = sample_cnt == CNT_W'(SAMPLE_CNT - 1);

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      sample_cnt <= '0;
      samp_a <= 1'b0;
      samp_b <= 1'b0;
      samp_d <= 1'b0;
    end
    else
    begin
      sample_cnt <= sample_tick ? '0 : sample_cnt + 1'b1;
      if (sample_tick)
      begin
        samp_a <= sel_a_on;
        samp_b <= sel_b_on;
        samp_d <= dir_on;
      end
    end
  end

  // ----------------------------------------------------------------
  // speed selection
  // ----------------------------------------------------------------
  wire both_off = !samp_a && !samp_b;
  wire [SPEED_W-1:0] preset_raw = (!samp_a && samp_b) ? preset_speed_one_i :
    (samp_a && samp_b) ? preset_speed_two_i : preset_speed_three_i;
  wire [SPEED_W-1:0] preset_clamped = (preset_raw > max_speed_i) ? max_speed_i : preset_raw;
  wire signed [REF_W-1:0] preset_mag = REF_W'(preset_clamped);
  wire signed [REF_W-1:0] preset_signed = samp_d ? -preset_mag : preset_mag;
  wire signed [REF_W-1:0] max_mag = REF_W'(max_speed_i);

  csss_src_t src;
  always_comb
  begin
    src = SRC_ANALOG_SPEED;
    if (contact_mode && !both_off)
      src = SRC_SPEED;
    else if (contact_mode)
    begin
      case (control_method_select_i)
        MODE_STOP: src = SRC_SPEED;
        MODE_ASPEED: src = SRC_ANALOG_SPEED;
        MODE_PULSE: src = SRC_PULSE;
        MODE_ATORQUE: src = SRC_TORQUE;
        default: src = SRC_ANALOG_SPEED;
      endcase
    end
  end

  wire preset_active = contact_mode && !both_off;
  wire signed [REF_W-1:0] target = preset_active ? preset_signed :
    (src == SRC_ANALOG_SPEED) ? analog_speed_ref_i : REF_ZERO;

  // ----------------------------------------------------------------
  // soft start ramp
  // ----------------------------------------------------------------
  logic signed [REF_W-1:0] ref_q;
  logic [DEN_W:0] acc;
  wire going_up = target > ref_q;
  wire at_target = target == ref_q;
  wire away_zero = going_up ? (ref_q >= REF_ZERO) : (ref_q <= REF_ZERO);
  wire [TIME_W-1:0] time_sel = away_zero ? accel_time : decel_time;
  wire [DEN_W-1:0] denom = DEN_W'(time_sel) * DEN_W'(CYCLES_MS);
  wire both_zero = (accel_time == TIME_RESET) && (decel_time == TIME_RESET);
  wire bypass = (src == SRC_PULSE) || (src == SRC_TORQUE);
  wire no_ramp = bypass || both_zero || (time_sel == TIME_RESET)
    || (max_speed_i == '0);
  wire [DEN_W:0] acc_sum = acc + (DEN_W + 1)'(max_speed_i);
  wire step_now = acc_sum >= {1'b0, denom};
  wire [DEN_W:0] next_acc = at_target ? '0 : step_now ? acc_sum - {1'b0, denom} : acc_sum;
  wire signed [REF_W-1:0] ref_step = going_up ? ref_q + 16'sh0001 : ref_q - 16'sh0001;
  wire signed [REF_W-1:0] next_ref = no_ramp ? target :
    (at_target || !step_now) ? ref_q : ref_step;

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      ref_q <= REF_ZERO;
      acc <= '0;
    end
    else
    begin
      ref_q <= next_ref;
      acc <= no_ramp ? '0 : next_acc;
    end
  end

  // ----------------------------------------------------------------
  // pulse gating after preset-to-pulse switch
  // ----------------------------------------------------------------
  csss_src_t src_prev;
  logic prev_preset;
  logic pulse_block;
  wire enter_pulse = (src == SRC_PULSE) && (src_prev != SRC_PULSE)
    && prev_preset && (ref_q != REF_ZERO);
  wire next_block = enter_pulse || (pulse_block && !position_done_i);

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      src_prev <= SRC_ANALOG_SPEED;
      prev_preset <= 1'b0;
      pulse_block <= 1'b0;
      ref_pulse_o <= 1'b0;
      position_done_n_o <= 1'b1;
    end
    else
    begin
      src_prev <= src;
      prev_preset <= preset_active;
      pulse_block <= next_block;
      ref_pulse_o <= pulse_in && (src == SRC_PULSE) && !next_block;
      position_done_n_o <= ~position_done_i;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      torque_ref_o <= REF_ZERO;
      ref_source_o <= SRC_ANALOG_SPEED;
      fwd_torque_limit_o <= 1'b0;
      rev_torque_limit_o <= 1'b0;
      prop_control_o <= 1'b0;
      direction_reverse_o <= 1'b0;
      contact_mode_o <= 1'b0;
    end
    else
    begin
      torque_ref_o <= (src == SRC_TORQUE) ? analog_torque_ref_i : REF_ZERO;
      ref_source_o <= src;
      fwd_torque_limit_o <= !contact_mode && sel_a_on;
      rev_torque_limit_o <= !contact_mode && sel_b_on;
      prop_control_o <= !contact_mode && dir_on;
      direction_reverse_o <= contact_mode && samp_d;
      contact_mode_o <= contact_mode;
    end
  end

  assign speed_ref_o = ref_q;
  assign pulse_blocked_o = pulse_block;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic signed [REF_W-1:0] ref_last;

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      ref_last <= REF_ZERO;
    else
      ref_last <= ref_q;
  end

  wire signed [REF_W-1:0] ref_delta = ref_q - ref_last;

  AST_ACCEL_RANGE: assert property (@(posedge clk_i) disable iff (reset_i)
    time_wr_i && !accel_ok |=> accel_ramp_time_o == $past(accel_ramp_time_o))
    else $error("accel time accepted out of range");

  AST_DECEL_LOAD: assert property (@(posedge clk_i) disable iff (reset_i)
    time_wr_i && decel_ok |=> decel_ramp_time_o == $past(decel_ramp_time_i))
    else $error("decel time not loaded");

  AST_STEP_LIMIT: assert property (@(posedge clk_i) disable iff (reset_i)
    !no_ramp && $stable(target) ##1 !no_ramp |-> (ref_delta <= 1 && ref_delta >= -1))
    else $error("ramp stepped by more than one");

  AST_NO_OVERSHOOT: assert property (@(posedge clk_i) disable iff (reset_i)
    !no_ramp && going_up && $stable(target) |=> speed_ref_o <= $past(target))
    else $error("ramp passed its target");

  AST_NO_UNDERSHOOT: assert property (@(posedge clk_i) disable iff (reset_i)
    !no_ramp && !going_up && !at_target && $stable(target) |=> speed_ref_o >= $past(target))
    else $error("ramp fell below its target");

  AST_IMMEDIATE: assert property (@(posedge clk_i) disable iff (reset_i)
    both_zero |=> speed_ref_o == $past(target))
    else $error("reference not applied at once");

  AST_STOP_ZERO: assert property (@(posedge clk_i) disable iff (reset_i)
    contact_mode && both_off && control_method_select_i == MODE_STOP |-> target == REF_ZERO)
    else $error("stop mode target not zero");

  AST_SPEED_TWO: assert property (@(posedge clk_i) disable iff (reset_i)
    contact_mode && samp_a && samp_b && !samp_d && preset_speed_two_i <= max_speed_i
    |-> target == REF_W'(preset_speed_two_i))
    else $error("speed two not selected");

  AST_REVERSE: assert property (@(posedge clk_i) disable iff (reset_i)
    preset_active && samp_d |-> target <= REF_ZERO)
    else $error("reverse direction ignored");

  AST_CLAMP: assert property (@(posedge clk_i) disable iff (reset_i)
    preset_active |-> (target <= max_mag && target >= -max_mag))
    else $error("preset not clamped");

  AST_PULSE_HELD: assert property (@(posedge clk_i) disable iff (reset_i)
    pulse_block && !position_done_i |=> !ref_pulse_o ##0 pulse_blocked_o)
    else $error("pulse passed before positioning done");

  AST_TORQUE_LIMIT: assert property (@(posedge clk_i) disable iff (reset_i)
    !contact_mode |=> fwd_torque_limit_o == $past(sel_a_on))
    else $error("torque limit enable wrong");

  AST_SAMPLE_PERIOD: assert property (@(posedge clk_i) disable iff (reset_i)
    sample_cnt < CNT_W'(SAMPLE_CNT))
    else $error("sample counter overran");
endmodule

// ---- verif/csss_host_model.sv ----
`timescale 1ns/10ps
module csss_host_model (
  // clock
  input wire logic clk_i,
  // commands from the bench
  input wire logic sel_a_i,
  input wire logic sel_b_i,
  input wire logic dir_i,
  input wire logic pulse_en_i,
  input wire logic early_i,
  // device status
  input wire logic position_done_n_i,
  // contact pins, active low
  output logic speed_select_a_n_o,
  output logic speed_select_b_n_o,
  output logic direction_select_n_o,
  output logic ref_pulse_n_o
);
  logic phase;

  initial phase = 1'b0;

  // ----------------------------------------------------------------
  // contact levels: on pulls the pin low
  // ----------------------------------------------------------------
  assign speed_select_a_n_o = ~sel_a_i;
  assign speed_select_b_n_o = ~sel_b_i;
  assign direction_select_n_o = ~dir_i;

  // ----------------------------------------------------------------
  // pulse train, held off until positioning is done unless told early
  // ----------------------------------------------------------------
  always @(negedge clk_i)
  begin
    phase <= ~phase;
  end
  assign ref_pulse_n_o = ~(pulse_en_i & (early_i | ~position_done_n_i) & phase);
endmodule

// ---- verif/contact_speed_select_soft_start_tb.sv ----
`timescale 1ns/10ps
module contact_speed_select_soft_start_tb;
  import csss_pkg::*;
  localparam int CMS = 20;
  localparam int SCNT = 4;
  typedef struct { int kind; logic [15:0] v; } csss_note_t;
  logic clk, reset, sel_a, sel_b, dir, pulse_en, early, asg_a, asg_b, asg_d, time_wr, pos_done;
  logic [MODE_W-1:0] mode;
  logic [TIME_W-1:0] accel, decel, acc_o, dec_o;
  logic [SPEED_W-1:0] p1, p2, p3, maxs;
  logic signed [REF_W-1:0] aspeed, atorque, speed_ref, torque_ref, last_ref;
  logic a_n, b_n, d_n, pulse_n, pulse_o, blocked, done_n, cmode, rev_o, fwd_tl, rev_tl, prop;
  logic ramp_on;
  logic [15:0] lfsr;
  csss_src_t src;
  csss_note_t notes[$];
  csss_note_t note;
  event chk;
  int mismatches, n_compared, npulse, jumps, n, mag;

  csss_host_model csss_host_model_i (.clk_i(clk), .sel_a_i(sel_a), .sel_b_i(sel_b),
    .dir_i(dir), .pulse_en_i(pulse_en), .early_i(early), .position_done_n_i(done_n),
    .speed_select_a_n_o(a_n), .speed_select_b_n_o(b_n), .direction_select_n_o(d_n),
    .ref_pulse_n_o(pulse_n));

  csss_speed_select #(.CYCLES_MS(CMS), .SAMPLE_CNT(SCNT)) csss_speed_select_i (
    .clk_i(clk), .reset_i(reset), .speed_select_a_n_i(a_n), .speed_select_b_n_i(b_n),
    .direction_select_n_i(d_n), .ref_pulse_i(pulse_n), .control_method_select_i(mode),
    .assign_a_i(asg_a), .assign_b_i(asg_b), .assign_d_i(asg_d), .time_wr_i(time_wr),
    .accel_ramp_time_i(accel), .decel_ramp_time_i(decel), .preset_speed_one_i(p1),
    .preset_speed_two_i(p2), .preset_speed_three_i(p3), .max_speed_i(maxs),
    .analog_speed_ref_i(aspeed), .analog_torque_ref_i(atorque), .position_done_i(pos_done),
    .speed_ref_o(speed_ref), .torque_ref_o(torque_ref), .ref_source_o(src),
    .ref_pulse_o(pulse_o), .pulse_blocked_o(blocked), .position_done_n_o(done_n),
    .contact_mode_o(cmode), .direction_reverse_o(rev_o), .fwd_torque_limit_o(fwd_tl),
    .rev_torque_limit_o(rev_tl), .prop_control_o(prop), .accel_ramp_time_o(acc_o),
    .decel_ramp_time_o(dec_o));

  // ----------------------------------------------------------------
  // clock, pulse counter and jump watch
  // ----------------------------------------------------------------
  always #2 clk = ~clk;

  always @(posedge clk)
  begin
    if (pulse_o === 1'b1)
      npulse++;
  end

  always @(negedge clk)
  begin
    if (ramp_on && (speed_ref - last_ref > 1 || last_ref - speed_ref > 1))
      jumps++;
    last_ref = speed_ref;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    if (mismatches == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic cmp_word(input string what, input logic [15:0] e, input logic [15:0] a);
    n_compared++;
    if (a !== e)
    begin
      mismatches++;
      $display("[ERR] %0t %s exp %h got %h", $time, what, e, a);
    end
  endtask

  task automatic expect_val(input int kind, input logic [15:0] v);
    notes.push_back('{kind, v});
  endtask

  task automatic check_now();
    -> chk;
    @(negedge clk);
  endtask

  task automatic settle();
    repeat (2 * CMS + 3) @(negedge clk);
  endtask

  task automatic write_times(input logic [TIME_W-1:0] a, input logic [TIME_W-1:0] d);
    accel = a;
    decel = d;
    time_wr = 1'b1;
    @(negedge clk);
    time_wr = 1'b0;
  endtask

  task automatic wait_ref(input logic [15:0] v);
    n = 0;
    while (speed_ref !== v)
    begin
      @(negedge clk);
      n++;
      if (n > 400)
      begin
        mismatches++;
        $display("[ERR] %0t wait for speed %h timed out", $time, v);
        tally_and_finish();
      end
    end
  endtask

  task automatic rnd(output logic [SPEED_W-1:0] v);
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    v = SPEED_W'(lfsr % 16'd10001);
  endtask

  // ----------------------------------------------------------------
  // result watcher: every queued note, oldest first, against the outputs
  // ----------------------------------------------------------------
  always @(chk)
  begin
    while (notes.size() > 0)
    begin
      note = notes.pop_front();
      case (note.kind)
        0: cmp_word("speed", note.v, speed_ref);
        1: cmp_word("torque", note.v, torque_ref);
        2: cmp_word("accel", note.v, {2'h0, acc_o});
        3: cmp_word("decel", note.v, {2'h0, dec_o});
        4: cmp_word("source", note.v, {14'h0, src});
        default: cmp_word("flags", note.v, {9'h0, cmode, rev_o, fwd_tl, rev_tl, prop, blocked, done_n});
      endcase
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk = 0; reset = 1; sel_a = 0; sel_b = 0; dir = 0; pulse_en = 0; early = 0;
    asg_a = 1; asg_b = 1; asg_d = 1; time_wr = 0; accel = 0; decel = 0; pos_done = 0;
    mode = MODE_STOP; p1 = 14'h0064; p2 = 14'h00c8; p3 = 14'h012c; maxs = 14'h1388;
    aspeed = 16'h0123; atorque = 16'hff00; lfsr = 16'h5b61; ramp_on = 0; last_ref = 0;
    mismatches = 0; n_compared = 0; npulse = 0; jumps = 0;
    repeat (5) @(negedge clk);
    reset = 0;
    expect_val(2, 16'h0000);
    expect_val(3, 16'h0000);
    expect_val(5, 16'h0001);
    check_now();
    write_times(14'h2710, 14'h2711);
    expect_val(2, 16'h2710);
    expect_val(3, 16'h0000);
    check_now();
    write_times(14'h0000, 14'h0000);
    for (int i = 0; i < 8; i++)
    begin
      rnd(p1); rnd(p2); rnd(p3); rnd(maxs);
      sel_a = 1'(i >> 1); sel_b = 1'(i); dir = 1'(i >> 2);
      settle();
      case (i % 4)
        1: mag = p1;
        3: mag = p2;
        2: mag = p3;
        default: mag = 0;
      endcase
      if (mag > maxs)
        mag = maxs;
      expect_val(0, dir ? 16'(-mag) : 16'(mag));
      expect_val(5, 16'({1'b1, dir, 5'h01}));
      check_now();
    end
    sel_a = 0; sel_b = 0; dir = 0;
    for (int m = 3; m <= 6; m++)
    begin
      mode = MODE_W'(m);
      settle();
      expect_val(0, (m == 4) ? aspeed : 16'h0000);
      expect_val(1, (m == 6) ? atorque : 16'h0000);
      expect_val(4, {14'h0, (m == 3) ? SRC_SPEED : (m == 4) ? SRC_ANALOG_SPEED :
        (m == 5) ? SRC_PULSE : SRC_TORQUE});
      check_now();
    end
    mode = 4'h0; sel_a = 1; sel_b = 1; dir = 1;
    settle();
    expect_val(5, 16'h001d);
    check_now();
    mode = MODE_STOP; asg_d = 0;
    settle();
    expect_val(5, 16'h001d);
    check_now();
    asg_d = 1; sel_a = 0; sel_b = 0; dir = 0; maxs = 14'd10; p1 = 14'd10; p3 = 14'd7;
    settle();
    write_times(14'd1, 14'd2);
    ramp_on = 1; sel_b = 1;
    wait_ref(16'd1);
    wait_ref(16'd10);
    cmp_word("rise", 16'(n), 16'(9 * CMS / 10));
    sel_b = 0;
    wait_ref(16'd9);
    wait_ref(16'd5);
    cmp_word("fall", 16'(n), 16'(4 * 2 * CMS / 10));
    sel_a = 1;
    wait_ref(16'd7);
    sel_a = 0;
    wait_ref(16'd0);
    ramp_on = 0;
    cmp_word("jumps", 16'(jumps), 16'h0000);
    write_times(14'h0000, 14'h0000);
    maxs = 14'h2710; p1 = 14'h0064; mode = MODE_PULSE; sel_b = 1;
    settle();
    expect_val(0, 16'h0064);
    check_now();
    early = 1; pulse_en = 1; sel_b = 0;
    settle();
    npulse = 0;
    settle();
    expect_val(5, 16'h0043);
    expect_val(4, {14'h0, SRC_PULSE});
    check_now();
    cmp_word("early", 16'(npulse), 16'h0000);
    early = 0; pos_done = 1;
    repeat (3) @(negedge clk);
    npulse = 0;
    repeat (20) @(negedge clk);
    expect_val(5, 16'h0040);
    check_now();
    cmp_word("pass", 16'(npulse > 0), 16'h0001);
    tally_and_finish();
  end
endmodule
